// File: hw/rcf_pkg.sv
package rcf_pkg;

  // Register bus geometry
  localparam int         RCF_AW           = 8;

  // Register byte offsets
  localparam logic [7:0] RCF_OFF_CAUSE    = 8'h00;
  localparam logic [7:0] RCF_OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] RCF_OFF_IRQ_MASK = 8'h08;

  // Field positions in reset_cause_status and the interrupt registers
  localparam int         RCF_BIT_CFG      = 9;
  localparam int         RCF_BIT_REG      = 8;
  localparam int         RCF_BIT_PIN      = 7;
  localparam int         RCF_BIT_SOFT     = 6;
  localparam int         RCF_BIT_WDOG     = 4;
  localparam int         RCF_BIT_SLEEP    = 3;
  localparam int         RCF_BIT_IDLE     = 2;
  localparam int         RCF_BIT_BROWN    = 1;
  localparam int         RCF_BIT_POR      = 0;

  // Hardware-set flags, and all bits software may write
  localparam logic [31:0] RCF_FLAG_MASK   = 32'h0000_02df;
  localparam logic [31:0] RCF_CAUSE_WMASK = 32'h0000_03df;

  // Reset values
  localparam logic [31:0] RCF_CAUSE_RST    = 32'h0000_0003;
  localparam logic [31:0] RCF_IRQ_STAT_RST = 32'h0000_0000;
  localparam logic [31:0] RCF_IRQ_MASK_RST = 32'h0000_0000;
  localparam logic        RCF_PIN_IDLE     = 1'h1;

  // AXI response codes
  localparam logic [1:0]  RCF_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RCF_RESP_SLVERR = 2'h2;

endpackage

// File: hw/rcf_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rcf_pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Raw pin and filtered level
  input  wire logic pin_raw,
  output logic      level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only once the second and third stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_q <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level = level_q;

endmodule

`default_nettype wire

// File: hw/rcf_reset_cause_flags.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Configuration-mismatch reset sets flag bit 9; zero means none occurred.
// R2: Bit 8 selects regulator in sleep: one on, zero standby tracking; resets zero.
// R3: Master-clear pin reset sets flag bit 7; otherwise it stays zero.
// R4: Software-requested reset sets flag bit 6.
// R5: Watchdog expiry sets flag bit 4.
// R6: Wake or reset while in sleep mode sets flag bit 3.
// R7: Wake or reset while in idle mode sets flag bit 2.
// R8: Brown-out reset sets flag bit 1; it is one after power-on.
// R9: Power-on reset sets flag bit 0; it is one after power-on.
// R10: Software clears brown-out and power-on flags after reading to see the next one.
// R11: All flags are hardware-set and software read/write; others start at zero.
// R12: Bit 5 and bits 31 to 10 read zero and ignore writes.
// R13: Flags set independently and stay set until software clears them.
module rcf_reset_cause_flags (
  // Clock and power-on reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // AXI4-Lite write address
  input  wire logic [rcf_pkg::RCF_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [rcf_pkg::RCF_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Reset and wake events from the system, one-cycle pulses
  input  wire logic                       cfg_mismatch_evt,
  input  wire logic                       soft_reset_evt,
  input  wire logic                       watchdog_expiry_evt,
  input  wire logic                       brownout_evt,
  input  wire logic                       wake_evt,
  // Power mode before the event, levels
  input  wire logic                       sleep_mode,
  input  wire logic                       idle_mode,
  // Master-clear pin, asynchronous, active low
  input  wire logic                       master_clear_pin_n,
  // Outputs to the system
  output logic                            regulator_sleep_select,
  output logic                            irq
);

  import rcf_pkg::*;

  typedef enum logic [3:0] {
    RCF_WR_IDLE = 4'h1,
    RCF_WR_ADDR = 4'h2,
    RCF_WR_DATA = 4'h4,
    RCF_WR_RESP = 4'h8
  } rcf_wr_state_t;

  rcf_wr_state_t       wr_state_q;
  rcf_wr_state_t       wr_state_d;
  logic [RCF_AW-1:0]   awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;

  logic                aw_hs;
  logic                w_hs;
  logic                ar_hs;
  logic                do_write;
  logic [RCF_AW-1:0]   wr_addr;
  logic [31:0]         wr_data;
  logic [3:0]          wr_strb;
  logic [31:0]         byte_mask;
  logic                wr_mapped;

  logic [31:0]         cause_q;
  logic [31:0]         cause_d;
  logic [31:0]         cause_wval;
  logic                cause_wr;
  logic [31:0]         irq_stat_q;
  logic [31:0]         irq_stat_d;
  logic [31:0]         irq_clr;
  logic [31:0]         irq_mask_q;
  logic [31:0]         irq_mask_d;
  logic                stat_wr;
  logic                mask_wr;

  logic [31:0]         rd_data;
  logic                rd_mapped;

  logic                pin_level;
  logic                pin_prev_q;
  logic                pin_reset_evt;
  logic                any_reset_evt;
  logic                wake_or_reset;
  logic [31:0]         hw_set;

  // Write channel: address and data may arrive in either order
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;

  always_comb begin
    s_axi_awready = 1'b0;
    s_axi_wready  = 1'b0;
    s_axi_bvalid  = 1'b0;
    do_write      = 1'b0;
    wr_state_d    = wr_state_q;
    unique case (wr_state_q)
      RCF_WR_IDLE: begin
        s_axi_awready = 1'b1;
        s_axi_wready  = 1'b1;
        if (s_axi_awvalid && s_axi_wvalid) begin
          do_write   = 1'b1;
          wr_state_d = RCF_WR_RESP;
        end else if (s_axi_awvalid) begin
          wr_state_d = RCF_WR_ADDR;
        end else if (s_axi_wvalid) begin
          wr_state_d = RCF_WR_DATA;
        end
      end
      RCF_WR_ADDR: begin
        s_axi_wready = 1'b1;
        if (s_axi_wvalid) begin
          do_write   = 1'b1;
          wr_state_d = RCF_WR_RESP;
        end
      end
      RCF_WR_DATA: begin
        s_axi_awready = 1'b1;
        if (s_axi_awvalid) begin
          do_write   = 1'b1;
          wr_state_d = RCF_WR_RESP;
        end
      end
      RCF_WR_RESP: begin
        s_axi_bvalid = 1'b1;
        if (s_axi_bready) begin
          wr_state_d = RCF_WR_IDLE;
        end
      end
      default: begin
        wr_state_d = RCF_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_state_q <= RCF_WR_IDLE;
    end else begin
      wr_state_q <= wr_state_d;
    end
  end

  // Hold whichever half of the write came first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Late half comes straight from the bus, early half from its hold
  assign wr_addr = (wr_state_q == RCF_WR_ADDR) ? awaddr_q : s_axi_awaddr;
  assign wr_data = (wr_state_q == RCF_WR_DATA) ? wdata_q : s_axi_wdata;
  assign wr_strb = (wr_state_q == RCF_WR_DATA) ? wstrb_q : s_axi_wstrb;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_byte
      assign byte_mask[8*b +: 8] = {8{wr_strb[b]}};
    end
  endgenerate

  assign cause_wr  = do_write && (wr_addr == RCF_OFF_CAUSE);
  assign stat_wr   = do_write && (wr_addr == RCF_OFF_IRQ_STAT);
  assign mask_wr   = do_write && (wr_addr == RCF_OFF_IRQ_MASK);
  assign wr_mapped = cause_wr || stat_wr || mask_wr;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bresp_q <= RCF_RESP_OKAY;
    end else if (do_write) begin
      bresp_q <= wr_mapped ? RCF_RESP_OKAY : RCF_RESP_SLVERR;
    end
  end

  assign s_axi_bresp = bresp_q;

  // Read channel: one read outstanding, answer one cycle after address
  assign s_axi_arready = !rvalid_q;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_data   = '0;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      RCF_OFF_CAUSE:    rd_data = cause_q;
      RCF_OFF_IRQ_STAT: rd_data = irq_stat_q;
      RCF_OFF_IRQ_MASK: rd_data = irq_mask_q;
      default:          rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RCF_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data;
      rresp_q  <= rd_mapped ? RCF_RESP_OKAY : RCF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // Master-clear pin: filtered, flag taken on assertion
  rcf_pin_sync #(
    .RESET_VAL (RCF_PIN_IDLE)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_raw  (master_clear_pin_n),
    .level    (pin_level)
  );

  // Pin already low at reset release counts as one assertion
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_prev_q <= RCF_PIN_IDLE;
    end else begin
      pin_prev_q <= pin_level;
    end
  end

  assign pin_reset_evt = pin_prev_q && !pin_level; // [R3]

  // Any non-power-on reset also records the prior power mode
  assign any_reset_evt = cfg_mismatch_evt || pin_reset_evt || soft_reset_evt
                      || watchdog_expiry_evt || brownout_evt;
  assign wake_or_reset = wake_evt || any_reset_evt;

  always_comb begin
    hw_set                = '0;
    hw_set[RCF_BIT_CFG]   = cfg_mismatch_evt;              // [R1]
    hw_set[RCF_BIT_PIN]   = pin_reset_evt;                 // [R3]
    hw_set[RCF_BIT_SOFT]  = soft_reset_evt;                // [R4]
    hw_set[RCF_BIT_WDOG]  = watchdog_expiry_evt;           // [R5]
    hw_set[RCF_BIT_SLEEP] = wake_or_reset && sleep_mode;   // [R6]
    hw_set[RCF_BIT_IDLE]  = wake_or_reset && idle_mode;    // [R7]
    hw_set[RCF_BIT_BROWN] = brownout_evt;                  // [R8]
    // Power-on flag comes only from rst
    hw_set[RCF_BIT_POR]   = 1'b0;                          // [R9]
  end

  // Software value merged under byte strobes, reserved bits dropped
  assign cause_wval = ((cause_q & ~byte_mask) | (wr_data & byte_mask))
                    & RCF_CAUSE_WMASK; // [R12]

  // Per-bit next value; a hardware set beats a same-cycle software clear
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_cause
      if (RCF_FLAG_MASK[i]) begin : g_flag
        assign cause_d[i] = hw_set[i]
                          | (cause_wr ? cause_wval[i] : cause_q[i]); // [R11] [R13]
      end else if (i == RCF_BIT_REG) begin : g_reg
        assign cause_d[i] = cause_wr ? cause_wval[i] : cause_q[i]; // [R2]
      end else begin : g_rsvd
        assign cause_d[i] = 1'b0; // [R12]
      end
    end
  endgenerate

  // Power-on reset leaves the brown-out and power-on flags set
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cause_q <= RCF_CAUSE_RST; // [R8] [R9] [R2] [R11]
    end else begin
      cause_q <= cause_d; // [R10]
    end
  end

  assign regulator_sleep_select = cause_q[RCF_BIT_REG]; // [R2]

  // Interrupt status: sticky, write one to clear, set wins
  assign irq_clr    = stat_wr ? (wr_data & byte_mask) : '0;
  assign irq_stat_d = ((irq_stat_q & ~irq_clr) | hw_set) & RCF_FLAG_MASK;
  assign irq_mask_d = ((irq_mask_q & ~byte_mask) | (wr_data & byte_mask))
                    & RCF_FLAG_MASK;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= RCF_IRQ_STAT_RST;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Mask is plain read/write; reserved bits stay zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= RCF_IRQ_MASK_RST;
    end else if (mask_wr) begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // Level output while any unmasked status bit stands
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

// File: verif/rcf_props.sv
`timescale 1ns/1ps
`default_nettype none
module rcf_props import rcf_pkg::*; (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // System outputs
  input wire logic        regulator_sleep_select,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open during response");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
  chk_b_onecyc: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during data");
  chk_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0
    && !s_axi_rdata[5]) else $error("reserved bit read as one");
  chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == RCF_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read with data");
  chk_reg_write: assert property ($changed(regulator_sleep_select)
    |-> $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready))
    else $error("regulator bit moved alone");
  chk_irq_clear: assert property ($fell(irq)
    |-> $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready))
    else $error("interrupt dropped without write");

  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == RCF_RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rdata[7]);
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
bind rcf_reset_cause_flags rcf_props u_props (.core_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .s_axi_rresp, .regulator_sleep_select, .irq);
module testbench;
  import rcf_pkg::*;
  logic        core_clk, rst, irq, regulator_sleep_select;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, e;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, sleep_mode, idle_mode;
  logic        master_clear_pin_n;
  logic [4:0]  ev;
  int          num_errors, num_checks, cyc;
  int          bt[6] = '{9, 6, 4, 1, 3, 2};

  rcf_reset_cause_flags u_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cfg_mismatch_evt(ev[4]), .soft_reset_evt(ev[3]), .watchdog_expiry_evt(ev[2]),
    .brownout_evt(ev[1]), .wake_evt(ev[0]), .sleep_mode, .idle_mode,
    .master_clear_pin_n, .regulator_sleep_select, .irq);

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (aw || w) begin
      @(posedge core_clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, x);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask

  // One-cycle event with the power mode of that cycle
  task automatic pulse(input logic [4:0] v, input logic s, input logic d);
    ev <= v;
    sleep_mode <= s;
    idle_mode <= d;
    @(posedge core_clk);
    ev <= 5'h0;
    sleep_mode <= 0;
    idle_mode <= 0;
    @(posedge core_clk);
  endtask

  task automatic rst_seq;
    rst <= 1;
    repeat (10) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
  endtask

  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    rst = 1;
    ev = 5'h0;
    {sleep_mode, idle_mode, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_bready, s_axi_rready, master_clear_pin_n} = 3'h7;
    s_axi_wstrb = 4'hf;
    rst_seq();
    rd(RCF_OFF_CAUSE, 32'h3, 2'h0);
    rd(RCF_OFF_IRQ_MASK, 32'h0, 2'h0);
    chk("regsel", 32'(regulator_sleep_select), 32'h0);
    $display("test reset values done");
    wr(RCF_OFF_CAUSE, 32'hffff_ffff, 2'h0);
    rd(RCF_OFF_CAUSE, 32'h3df, 2'h0);
    chk("regsel", 32'(regulator_sleep_select), 32'h1);
    wr(RCF_OFF_CAUSE, 32'h0, 2'h0);
    rd(RCF_OFF_CAUSE, 32'h0, 2'h0);
    $display("test write and clear done");
    e = 32'h0;
    for (int i = 0; i < 6; i++) begin
      pulse(i < 4 ? 5'h10 >> i : 5'h01, i == 4, i == 5);
      e |= 32'h1 << bt[i];
      rd(RCF_OFF_CAUSE, e, 2'h0);
    end
    rd(RCF_OFF_IRQ_STAT, e, 2'h0);
    chk("irq", 32'(irq), 32'h0);
    $display("test events done");
    wr(RCF_OFF_IRQ_MASK, 32'h10, 2'h0);
    chk("irq", 32'(irq), 32'h1);
    wr(RCF_OFF_IRQ_STAT, 32'h10, 2'h0);
    chk("irq", 32'(irq), 32'h0);
    rd(RCF_OFF_IRQ_STAT, e & ~32'h10, 2'h0);
    $display("test interrupt done");
    master_clear_pin_n <= 0;
    repeat (6) @(posedge core_clk);
    master_clear_pin_n <= 1;
    repeat (8) @(posedge core_clk);
    rd(RCF_OFF_CAUSE, e | 32'h80, 2'h0);
    wr(RCF_OFF_CAUSE, 32'h0, 2'h0);
    rd(RCF_OFF_CAUSE, 32'h0, 2'h0);
    $display("test pin done");
    // Event lands in the same cycle as a software clear
    fork
      wr(RCF_OFF_CAUSE, 32'h0, 2'h0);
      pulse(5'h04, 1'b0, 1'b0);
    join
    rd(RCF_OFF_CAUSE, 32'h10, 2'h0);
    chk("irq", 32'(irq), 32'h1);
    s_axi_wstrb <= 4'h1;
    wr(RCF_OFF_CAUSE, 32'hffff_ffff, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(RCF_OFF_CAUSE, 32'hdf, 2'h0);
    chk("regsel", 32'(regulator_sleep_select), 32'h0);
    $display("test set wins and strobes done");
    wr(8'h0c, 32'h1, 2'h2);
    rd(8'h0c, 32'h0, 2'h2);
    rst_seq();
    rd(RCF_OFF_CAUSE, 32'h3, 2'h0);
    $display("test unmapped and reset done");
    conclude();
  end
endmodule
`default_nettype wire
